// ### rgc_ringing_ctrl.v
// Ringing generator control: gating, turn-off modes, states, hook detection
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module rgc_ringing_ctrl (
	input wire sys_clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [8:0] phase,
	input wire cycle_wrap,
	input wire cadence_on,
	input wire clip_flag,
	input wire [15:0] dc_current,
	input wire [15:0] ac_impedance,
	input wire meas_valid,
	output reg ac_enable,
	output reg ac_mute,
	output reg phase_load,
	output reg [8:0] phase_init,
	output reg [2:0] wave_shape,
	output reg [2:0] gen_state,
	output reg off_hook,
	output reg irq
);
`include "rgc_regs.vh"

	// ======================================================================
	// Registers
	reg [7:0] ctrl_reg;
	reg [8:0] start_ph_reg;
	reg [8:0] end_ph_reg;
	reg [15:0] dc_thr_reg;
	reg [15:0] ac_lim_reg;
	reg [7:0] cyc_reg;
	reg [15:0] deb_ms_reg;
	reg [15:0] blank_ms_reg;
	reg [`RGC_IRQ_W-1:0] irq_stat_reg;
	reg [`RGC_IRQ_W-1:0] irq_en_reg;
	reg run_reg;
	reg pending_reg;
	reg [8:0] phase_prev_reg;
	reg load_dly_reg;
	reg raw_hook_reg;
	reg [31:0] deb_cnt_reg;
	reg [31:0] blank_cnt_reg;
	reg [7:0] low_cyc_reg;
	reg run_prev_reg;
	reg hook_prev_reg;

	wire [1:0] off_mode = ctrl_reg[`RGC_CTRL_OFFMODE_MSB:`RGC_CTRL_OFFMODE_LSB];
	wire [1:0] hook_act = ctrl_reg[`RGC_CTRL_ACTION_MSB:`RGC_CTRL_ACTION_LSB];
	wire cmd_wr = wr && (addr == `RGC_CMD_ADDR);
	wire start_cmd = cmd_wr && wdata[`RGC_CMD_START_BIT];
	wire stop_cmd = cmd_wr && wdata[`RGC_CMD_STOP_BIT];
	wire [31:0] deb_cycles = deb_ms_reg * `RGC_CYC_PER_MS;
	wire [31:0] blank_cycles = blank_ms_reg * `RGC_CYC_PER_MS;
	wire blanking = (blank_cnt_reg != 32'h0);

	// ======================================================================
	// Register writes
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			ctrl_reg <= `RGC_CTRL_RST;
			start_ph_reg <= `RGC_PH_ZERO;
			end_ph_reg <= `RGC_PH_ZERO;
			dc_thr_reg <= `RGC_DC_THR_RST;
			ac_lim_reg <= `RGC_AC_LIM_RST;
			cyc_reg <= `RGC_CYC_RST;
			deb_ms_reg <= `RGC_DEB_MS_RST;
			blank_ms_reg <= `RGC_BLANK_MS_RST;
			irq_en_reg <= {`RGC_IRQ_W{1'b0}};
		end else if (wr) begin
			case (addr)
				`RGC_CTRL_ADDR: begin
					if (wdata[`RGC_CTRL_SHAPE_MSB:`RGC_CTRL_SHAPE_LSB] <= `RGC_SHAPE_MAX)
						ctrl_reg <= wdata[`RGC_CTRL_CADENCE_BIT:`RGC_CTRL_SHAPE_LSB];
					else
						ctrl_reg <= {wdata[`RGC_CTRL_CADENCE_BIT:`RGC_CTRL_OFFMODE_LSB],
							ctrl_reg[`RGC_CTRL_SHAPE_MSB:`RGC_CTRL_SHAPE_LSB]};
				end
				`RGC_START_PH_ADDR: begin
					if (wdata[8:0] <= `RGC_PH_MAX)
						start_ph_reg <= wdata[8:0];
				end
				`RGC_END_PH_ADDR: begin
					if (wdata[8:0] <= `RGC_PH_MAX)
						end_ph_reg <= wdata[8:0];
				end
				`RGC_DC_THR_ADDR: dc_thr_reg <= wdata[15:0];
				`RGC_AC_LIM_ADDR: ac_lim_reg <= wdata[15:0];
				`RGC_CYC_ADDR: cyc_reg <= wdata[7:0];
				`RGC_DEB_ADDR: deb_ms_reg <= wdata[15:0];
				`RGC_BLANK_ADDR: blank_ms_reg <= wdata[15:0];
				`RGC_IRQ_EN_ADDR: irq_en_reg <= wdata[`RGC_IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Generator run control
	// Stop is wanted by command or by off-hook under the stop action
	wire stop_req = stop_cmd || (hook_act == `RGC_ACT_STOP && off_hook && !hook_prev_reg);
	wire hit_end = (phase == end_ph_reg);
	// Crossing 180 or wrap at 360
	// Edge after a phase load compares a stale phase, so it never counts as a crossing
	wire hit_half = !load_dly_reg &&
		((phase_prev_reg < `RGC_PH_180 && phase >= `RGC_PH_180) ||
		(phase < phase_prev_reg));
	wire end_reached = (off_mode == `RGC_OFF_END_PHASE) ? hit_end :
		(off_mode == `RGC_OFF_HALF_CYCLE) ? hit_half : 1'b1;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			run_reg <= 1'b0;
			pending_reg <= 1'b0;
			phase_prev_reg <= `RGC_PH_ZERO;
			load_dly_reg <= 1'b0;
			phase_load <= 1'b0;
			phase_init <= `RGC_PH_ZERO;
		end else begin
			phase_prev_reg <= phase;
			load_dly_reg <= phase_load;
			phase_load <= 1'b0;
			if (start_cmd && !run_reg) begin
				run_reg <= 1'b1;
				pending_reg <= 1'b0;
				phase_load <= 1'b1;
				phase_init <= start_ph_reg;
			end else if (run_reg && stop_req && !pending_reg) begin
				if (off_mode == `RGC_OFF_IMMEDIATE || off_mode == `RGC_OFF_RESERVED)
					run_reg <= 1'b0;
				else
					pending_reg <= 1'b1;
			end else if (pending_reg && end_reached) begin
				run_reg <= 1'b0;
				pending_reg <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Line state detection
	// Classification on each valid measurement outside blanking
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			raw_hook_reg <= 1'b0;
			low_cyc_reg <= 8'h00;
		end else if (meas_valid && !blanking) begin
			if (run_reg) begin
				if (ac_impedance >= ac_lim_reg)
					low_cyc_reg <= 8'h00;
				else if (cycle_wrap && low_cyc_reg < cyc_reg)
					low_cyc_reg <= low_cyc_reg + 8'h01;
				if (low_cyc_reg >= cyc_reg && ac_impedance < ac_lim_reg)
					raw_hook_reg <= 1'b1;
				else if (ac_impedance >= ac_lim_reg)
					raw_hook_reg <= 1'b0;
			end else begin
				low_cyc_reg <= 8'h00;
				raw_hook_reg <= (dc_current >= dc_thr_reg);
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			run_prev_reg <= 1'b0;
			blank_cnt_reg <= 32'h0;
			deb_cnt_reg <= 32'h0;
			off_hook <= 1'b0;
			hook_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= run_reg;
			hook_prev_reg <= off_hook;
			if (run_reg != run_prev_reg)
				blank_cnt_reg <= blank_cycles;
			else if (blanking)
				blank_cnt_reg <= blank_cnt_reg - 32'h1;
			if (raw_hook_reg == off_hook)
				deb_cnt_reg <= 32'h0;
			else if (deb_cnt_reg + 32'h1 >= deb_cycles) begin
				off_hook <= raw_hook_reg;
				deb_cnt_reg <= 32'h0;
			end else
				deb_cnt_reg <= deb_cnt_reg + 32'h1;
		end
	end

	// ======================================================================
	// Outputs to the waveform path
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			ac_enable <= 1'b0;
			ac_mute <= 1'b0;
			wave_shape <= 3'h0;
			gen_state <= `RGC_ST_OFF;
		end else begin
			ac_enable <= run_reg && (!ctrl_reg[`RGC_CTRL_CADENCE_BIT] || cadence_on);
			ac_mute <= (hook_act == `RGC_ACT_MUTE) && off_hook;
			wave_shape <= ctrl_reg[`RGC_CTRL_SHAPE_MSB:`RGC_CTRL_SHAPE_LSB];
			if (!run_reg)
				gen_state <= `RGC_ST_OFF;
			else if (pending_reg)
				gen_state <= `RGC_ST_PENDING;
			else if (hook_act == `RGC_ACT_MUTE && off_hook)
				gen_state <= `RGC_ST_MUTED;
			else if (clip_flag)
				gen_state <= `RGC_ST_CLIPPED;
			else
				gen_state <= `RGC_ST_ACTIVE;
		end
	end

	// ======================================================================
	// Interrupts: set wins over clear
	wire [`RGC_IRQ_W-1:0] irq_set = {run_prev_reg && !run_reg,
		hook_prev_reg && !off_hook, off_hook && !hook_prev_reg};
	wire [`RGC_IRQ_W-1:0] irq_clr = (wr && addr == `RGC_IRQ_CLR_ADDR) ?
		wdata[`RGC_IRQ_W-1:0] : {`RGC_IRQ_W{1'b0}};

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			irq_stat_reg <= {`RGC_IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
		end
	end

	// ======================================================================
	// Read port
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			rdata <= 32'h0;
		end else if (rd) begin
			case (addr)
				`RGC_CTRL_ADDR: rdata <= {24'h0, ctrl_reg};
				`RGC_START_PH_ADDR: rdata <= {23'h0, start_ph_reg};
				`RGC_END_PH_ADDR: rdata <= {23'h0, end_ph_reg};
				`RGC_DC_THR_ADDR: rdata <= {16'h0, dc_thr_reg};
				`RGC_AC_LIM_ADDR: rdata <= {16'h0, ac_lim_reg};
				`RGC_CYC_ADDR: rdata <= {24'h0, cyc_reg};
				`RGC_DEB_ADDR: rdata <= {16'h0, deb_ms_reg};
				`RGC_BLANK_ADDR: rdata <= {16'h0, blank_ms_reg};
				`RGC_STATE_ADDR: rdata <= {27'h0, raw_hook_reg, off_hook, gen_state};
				`RGC_IRQ_STAT_ADDR: rdata <= {29'h0, irq_stat_reg};
				`RGC_IRQ_EN_ADDR: rdata <= {29'h0, irq_en_reg};
				default: rdata <= 32'h0;
			endcase
		end else begin
			rdata <= 32'h0;
		end
	end

endmodule // rgc_ringing_ctrl

// ### rgc_regs.vh
// Register map, field layouts, reset values and timing constants of the ringing control
`ifndef RGC_REGS_VH
`define RGC_REGS_VH

// ==========================================================================
// Register offsets
`define RGC_CTRL_ADDR 8'h00
`define RGC_CMD_ADDR 8'h04
`define RGC_START_PH_ADDR 8'h08
`define RGC_END_PH_ADDR 8'h0c
`define RGC_DC_THR_ADDR 8'h10
`define RGC_AC_LIM_ADDR 8'h14
`define RGC_CYC_ADDR 8'h18
`define RGC_DEB_ADDR 8'h1c
`define RGC_BLANK_ADDR 8'h20
`define RGC_STATE_ADDR 8'h24
`define RGC_IRQ_STAT_ADDR 8'h28
`define RGC_IRQ_EN_ADDR 8'h2c
`define RGC_IRQ_CLR_ADDR 8'h30

// ==========================================================================
// Control fields
`define RGC_CTRL_SHAPE_LSB 0
`define RGC_CTRL_SHAPE_MSB 2
`define RGC_CTRL_OFFMODE_LSB 3
`define RGC_CTRL_OFFMODE_MSB 4
`define RGC_CTRL_ACTION_LSB 5
`define RGC_CTRL_ACTION_MSB 6
`define RGC_CTRL_CADENCE_BIT 7
`define RGC_CMD_START_BIT 0
`define RGC_CMD_STOP_BIT 1

// Turn-off modes
`define RGC_OFF_IMMEDIATE 2'h0
`define RGC_OFF_END_PHASE 2'h1
`define RGC_OFF_HALF_CYCLE 2'h2
`define RGC_OFF_RESERVED 2'h3
`define RGC_CTRL_RST 8'h00

// Off-hook actions
`define RGC_ACT_STOP 2'h0
`define RGC_ACT_MUTE 2'h1
`define RGC_ACT_NONE 2'h2

// Wave shapes
`define RGC_SHAPE_MAX 3'h5

// Operating state codes
`define RGC_ST_OFF 3'h0
`define RGC_ST_ACTIVE 3'h1
`define RGC_ST_MUTED 3'h2
`define RGC_ST_PENDING 3'h3
`define RGC_ST_CLIPPED 3'h4

// Interrupt bits
`define RGC_IRQ_OFFHOOK 0
`define RGC_IRQ_ONHOOK 1
`define RGC_IRQ_STOPPED 2
`define RGC_IRQ_W 3

// ==========================================================================
// Phase and defaults
`define RGC_PH_MAX 9'h167
`define RGC_PH_180 9'h0b4
`define RGC_PH_ZERO 9'h000
`define RGC_DC_THR_RST 16'h0064
`define RGC_AC_LIM_RST 16'h0320
`define RGC_CYC_RST 8'h02
`define RGC_DEB_MS_RST 16'h0002
`define RGC_BLANK_MS_RST 16'h0032
`define RGC_CLK_HZ 50000000
`define RGC_MS_PER_S 1000
`define RGC_CYC_PER_MS (`RGC_CLK_HZ / `RGC_MS_PER_S)

`endif

// ### rgc_line_model.sv
// Line-side model: waveform phase source and a telephone set on the line
`timescale 1ns/1ps
module rgc_line_model (
	input wire sys_clk,
	input wire hook,
	input wire ac_enable,
	input wire phase_load,
	input wire [8:0] phase_init,
	output reg [8:0] phase,
	output reg cycle_wrap,
	output wire [15:0] dc_current,
	output wire [15:0] ac_impedance,
	output wire meas_valid
);
	initial begin
		phase = 9'h000;
		cycle_wrap = 1'b0;
	end
	// ==========================================================
	// Phase steps one degree a clock and freezes while AC is off
	always @(posedge sys_clk) begin
		cycle_wrap <= 1'b0;
		if (phase_load) begin
			phase <= phase_init;
		end else if (ac_enable) begin
			phase <= (phase == 9'h167) ? 9'h000 : phase + 9'h001;
			cycle_wrap <= (phase == 9'h167);
		end
	end
	// Lifted handset draws 20 mA and shows 400 ohm, else 1 mA and 10 kohm
	assign dc_current = hook ? 16'h00c8 : 16'h000a;
	assign ac_impedance = hook ? 16'h0190 : 16'h2710;
	assign meas_valid = 1'b1;
endmodule // rgc_line_model

// ### rgc_ringing_ctrl_chk.sv
// Port checker of the ringing control
`timescale 1ns/1ps
`include "rgc_regs.vh"
module rgc_ringing_ctrl_chk (
	input wire sys_clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire [8:0] phase,
	input wire ac_enable,
	input wire phase_load,
	input wire [8:0] phase_init,
	input wire [2:0] wave_shape,
	input wire [2:0] gen_state,
	input wire off_hook
);
	reg [1:0] mode_reg;
	reg cad_reg;
	wire cmd_w = wr && addr == `RGC_CMD_ADDR;
	wire imm = mode_reg == `RGC_OFF_IMMEDIATE || mode_reg == `RGC_OFF_RESERVED;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Shadow of the turn-off mode and the cadence bit
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			mode_reg <= `RGC_OFF_IMMEDIATE;
			cad_reg <= 1'b0;
		end else if (wr && addr == `RGC_CTRL_ADDR) begin
			mode_reg <= wdata[`RGC_CTRL_OFFMODE_MSB:`RGC_CTRL_OFFMODE_LSB];
			cad_reg <= wdata[`RGC_CTRL_CADENCE_BIT];
		end
	end
	a_start_loads:
	assert property (cmd_w && wdata[1:0] == 2'h1 && gen_state == `RGC_ST_OFF && !ac_enable
		&& !phase_load && !off_hook |=> phase_load) else $error("start gave no load");
	// Cadence gating may hold AC low after a load or raise it later
	a_load_then_ac:
	assert property (phase_load && !cad_reg |=> ac_enable) else $error("no AC after load");
	a_ac_cause:
	assert property ($rose(ac_enable) && !cad_reg |-> $past(phase_load))
		else $error("AC without start");
	a_init_range:
	assert property (phase_load |-> phase_init <= `RGC_PH_MAX) else $error("start phase range");
	a_imm_stop:
	assert property (cmd_w && wdata[`RGC_CMD_STOP_BIT] && ac_enable && imm |=> ##1 !ac_enable)
		else $error("immediate stop late");
	a_half_stop:
	assert property (gen_state == `RGC_ST_PENDING && mode_reg == `RGC_OFF_HALF_CYCLE
		&& (phase == `RGC_PH_180 || phase == `RGC_PH_ZERO) |-> ##[1:3] !ac_enable)
		else $error("half cycle stop late");
	a_shape_range:
	assert property (wave_shape <= `RGC_SHAPE_MAX) else $error("shape out of range");
	a_state_code:
	assert property (gen_state <= `RGC_ST_CLIPPED) else $error("state code out of range");
endmodule // rgc_ringing_ctrl_chk
bind rgc_ringing_ctrl rgc_ringing_ctrl_chk chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr(wr), .phase(phase), .ac_enable(ac_enable),
	.phase_load(phase_load), .phase_init(phase_init), .wave_shape(wave_shape),
	.gen_state(gen_state), .off_hook(off_hook));

// ### rgc_ringing_ctrl_tb.sv
// Bench of the ringing control
`timescale 1ns/1ps
`include "rgc_regs.vh"
module rgc_ringing_ctrl_tb;
	reg sys_clk = 1'b0;
	reg rst_b = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [31:0] wdata = 32'h0;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg hook = 1'b0;
	reg cadence_on = 1'b1;
	reg clip_flag = 1'b0;
	reg [31:0] v;
	wire [31:0] rdata;
	wire [8:0] phase, phase_init;
	wire [15:0] dc_current, ac_impedance;
	wire cycle_wrap, meas_valid, ac_enable, ac_mute, phase_load, off_hook, irq;
	wire [2:0] wave_shape, gen_state;
	integer error_cnt = 0;
	integer cmp_count = 0;
	integer i;
	always #10 sys_clk = ~sys_clk;
	rgc_ringing_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .phase(phase), .cycle_wrap(cycle_wrap),
		.cadence_on(cadence_on), .clip_flag(clip_flag), .dc_current(dc_current),
		.ac_impedance(ac_impedance), .meas_valid(meas_valid), .ac_enable(ac_enable),
		.ac_mute(ac_mute), .phase_load(phase_load), .phase_init(phase_init),
		.wave_shape(wave_shape), .gen_state(gen_state), .off_hook(off_hook), .irq(irq));
	rgc_line_model line (.sys_clk(sys_clk), .hook(hook), .ac_enable(ac_enable),
		.phase_load(phase_load), .phase_init(phase_init), .phase(phase),
		.cycle_wrap(cycle_wrap), .dc_current(dc_current), .ac_impedance(ac_impedance),
		.meas_valid(meas_valid));
	// ==========================================================
	// Shared tasks
	task tally_and_finish;
		begin
			$display("checks %0d errors %0d", cmp_count, error_cnt);
			if (error_cnt == 0 && cmp_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task chk(input string n, input [31:0] e, input [31:0] g);
		begin
			cmp_count = cmp_count + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("wrong value %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task w(input [7:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			wr <= 1'b1;
			addr <= a;
			wdata <= d;
			@(posedge sys_clk);
			wr <= 1'b0;
		end
	endtask
	task r(input [7:0] a);
		begin
			@(posedge sys_clk);
			rd <= 1'b1;
			addr <= a;
			@(posedge sys_clk);
			rd <= 1'b0;
			#1;
			v = rdata;
		end
	endtask
	// Bounded wait on ac_enable (s=0) or off_hook (s=1)
	task wt(input s, input b, input integer lim);
		integer k;
		begin
			for (k = 0; k < lim && (s ? off_hook : ac_enable) !== b; k = k + 1) begin
				@(posedge sys_clk);
				#1;
			end
			if ((s ? off_hook : ac_enable) !== b) begin
				error_cnt = error_cnt + 1;
				$display("wrong value wait expected %b seen timeout", b);
				tally_and_finish;
			end
		end
	endtask
	// ==========================================================
	// Scenarios
	task t_defaults;
		begin
			r(`RGC_DC_THR_ADDR);
			chk("dc_thr", 32'h64, v);
			r(`RGC_AC_LIM_ADDR);
			chk("ac_lim", 32'h320, v);
			r(`RGC_CYC_ADDR);
			chk("cycles", 32'h2, v);
			r(`RGC_DEB_ADDR);
			chk("debounce", 32'h2, v);
			r(`RGC_BLANK_ADDR);
			chk("blank", 32'h32, v);
			r(8'hfc);
			chk("unmapped", 32'h0, v);
		end
	endtask
	task t_shapes;
		for (i = 0; i < 7; i = i + 1) begin
			w(`RGC_CTRL_ADDR, i);
			@(posedge sys_clk);
			#1;
			chk("shape", i > 5 ? 5 : i, wave_shape);
		end
	endtask
	task t_turn_off;
		begin
			w(`RGC_START_PH_ADDR, 32'h5a);
			w(`RGC_START_PH_ADDR, 32'h168);
			w(`RGC_END_PH_ADDR, 32'h12c);
			for (i = 0; i < 3; i = i + 1) begin
				w(`RGC_CTRL_ADDR, i << 3);
				w(`RGC_CMD_ADDR, 32'h1);
				wt(0, 1, 4);
				chk("phase_init", 32'h5a, phase_init);
				chk("state", `RGC_ST_ACTIVE, gen_state);
				w(`RGC_CMD_ADDR, 32'h2);
				repeat (2) @(posedge sys_clk);
				#1;
				chk("pending", i ? `RGC_ST_PENDING : `RGC_ST_OFF, gen_state);
				wt(0, 0, 400);
				v = i == 1 ? 32'h12c : 32'hb4;
				chk("end_phase", 1, i == 0 || (phase >= v && phase <= v + 2));
				chk("state", `RGC_ST_OFF, gen_state);
			end
		end
	endtask
	task t_hook;
		for (i = 0; i < 3; i = i + 1) begin
			w(`RGC_IRQ_CLR_ADDR, 32'h7);
			w(`RGC_IRQ_EN_ADDR, i == 2 ? 32'h2 : 32'h3);
			w(`RGC_CTRL_ADDR, i << 5);
			w(`RGC_CMD_ADDR, 32'h1);
			wt(0, 1, 4);
			@(posedge sys_clk);
			hook <= 1'b1;
			wt(1, 1, 2000);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("irq", i != 2, irq);
			chk("mute", i == 1, ac_mute);
			chk("state", i == 0 ? 0 : i == 1 ? 2 : 1, gen_state);
			@(posedge sys_clk);
			hook <= 1'b0;
			wt(1, 0, 2000);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("unmute", 0, ac_mute);
			chk("ac", i != 0, ac_enable);
			r(`RGC_IRQ_STAT_ADDR);
			chk("irq_stat", i ? 3 : 7, v);
			w(`RGC_IRQ_CLR_ADDR, 32'h7);
			w(`RGC_CMD_ADDR, 32'h2);
			wt(0, 0, 8);
			chk("irq_clr", 0, irq);
		end
	endtask
	// Cadence gate low with clipping, then released; reserved turn-off mode stops at once
	task t_cad_clip;
		begin
			w(`RGC_CTRL_ADDR, 32'h98);
			cadence_on <= 1'b0;
			clip_flag <= 1'b1;
			w(`RGC_CMD_ADDR, 32'h1);
			repeat (3) @(posedge sys_clk);
			#1;
			chk("cadence_gate", 0, ac_enable);
			chk("clip_state", `RGC_ST_CLIPPED, gen_state);
			r(`RGC_STATE_ADDR);
			chk("state_reg", `RGC_ST_CLIPPED, v);
			@(posedge sys_clk);
			cadence_on <= 1'b1;
			clip_flag <= 1'b0;
			wt(0, 1, 4);
			chk("cadence_open", 1, ac_enable);
			chk("active_state", `RGC_ST_ACTIVE, gen_state);
			w(`RGC_CMD_ADDR, 32'h2);
			repeat (2) @(posedge sys_clk);
			#1;
			chk("reserved_stop", 0, ac_enable);
			chk("off_state", `RGC_ST_OFF, gen_state);
			w(`RGC_CTRL_ADDR, 32'h0);
		end
	endtask
	// Long debounce and blanking are cut to zero to keep the run short
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		t_defaults;
		w(`RGC_DEB_ADDR, 32'h0);
		w(`RGC_BLANK_ADDR, 32'h0);
		t_shapes;
		t_turn_off;
		t_hook;
		t_cad_clip;
		tally_and_finish;
	end
endmodule // rgc_ringing_ctrl_tb
